// File: pkg/hfcrc_pkg.sv
// shared types and constants of the hdlc frame check unit
package hfcrc_pkg;

    // crc mode chosen by software, latched per frame
    typedef enum logic [1:0] {
        HFCRC_MODE_CCITT,
        HFCRC_MODE_CRC16,
        HFCRC_MODE_CRC32
    } hfcrc_mode_t;

    // source of the serial transmit pin
    typedef enum logic [1:0] {
        HFCRC_SRC_PACKETIZER,
        HFCRC_SRC_CLEAR,
        HFCRC_SRC_STATIC
    } hfcrc_txsrc_t;

    // what the packetizer puts in the next transmit bit slot
    typedef enum logic [1:0] {
        HFCRC_TXK_FLAG,
        HFCRC_TXK_DATA,
        HFCRC_TXK_STUFF,
        HFCRC_TXK_CHECK
    } hfcrc_txkind_t;

    typedef enum logic [1:0] {
        HFCRC_TX_IDLE,
        HFCRC_TX_BODY,
        HFCRC_TX_CHECK
    } hfcrc_txstate_t;

    // one transmit bit slot, valid while the bit request pulses
    typedef struct packed {
        hfcrc_txkind_t kind;
        logic          data;
        logic          frame_start;
        logic          byte_first;
    } hfcrc_tx_bit_t;

    // one sampled receive bit
    typedef struct packed {
        logic valid;
        logic data;
    } hfcrc_rx_bit_t;

    // receive checker commands from the packetizer, one-cycle strobes
    typedef struct packed {
        logic frame_start;
        logic shift;
        logic data;
        logic frame_close;
    } hfcrc_rx_ctrl_t;

    // receive verdict at the closing flag
    typedef struct packed {
        logic done;
        logic crc_bad;
    } hfcrc_rx_result_t;

    localparam logic [15:0] HFCRC_POLY16     = 16'h1021;
    localparam logic [31:0] HFCRC_POLY32     = 32'h04C11DB7;
    localparam logic [15:0] HFCRC_RESIDUE16  = 16'h1D0F;
    localparam logic [31:0] HFCRC_RESIDUE32  = 32'hC704DD7B;
    localparam logic [31:0] HFCRC_ONES16     = 32'h0000FFFF;
    localparam logic [31:0] HFCRC_ONES32     = 32'hFFFFFFFF;
    localparam logic [31:0] HFCRC_ZEROS      = 32'h00000000;
    localparam logic [5:0]  HFCRC_LEN16      = 6'h10;
    localparam logic [5:0]  HFCRC_LEN32      = 6'h20;
    localparam logic        HFCRC_RST_LINE   = 1'h1;
    localparam logic [2:0]  HFCRC_RST_SYNC   = 3'h7;

endpackage

// File: rtl/hfcrc_unit.sv
// hdlc frame check sequence generator and checker with serial pin handling
// How it works
// - transmit crc covers bits after opening flag to last data bit, stuffing excluded
// - both 16-bit modes use x16+x12+x5+1, one covered bit per shift
// - ccitt mode presets the transmit register to all ones per frame
// - ccitt and 32-bit modes send inverted register, most significant first
// - plain 16-bit mode presets the transmit register to all zeros
// - plain 16-bit mode sends the register uninverted, most significant first
// - receive register presets to all ones after each opening flag
// - receive computation skips stuffed zeros, tracking the transmitter
// - 16-bit modes expect residue 0x1D0F after the check field
// - wrong residue after the check field flags an invalid crc
// - 32-bit mode presets ones, uses the 32-bit ethernet-style polynomial
// - 32-bit mode expects residue 0xC704DD7B after the check field
// - transmit bits shift out on the modem's transmit bit clock
// - receive bits are sampled on the modem's receive bit clock
// - transmit pin picks packetizer, clear channel or static control level
// - transmit ready pulses on a message byte's first bit, never in check field
module hfcrc_unit
(
    input  wire logic                       REF_CLK_IN,
    input  wire logic                       RST_B_IN,
    input  wire hfcrc_pkg::hfcrc_mode_t     CRC_MODE_IN,
    input  wire hfcrc_pkg::hfcrc_txsrc_t    TX_SRC_SEL_IN,
    input  wire logic                       STATIC_LEVEL_IN,
    input  wire logic                       DTE_TXD_IN,
    input  wire logic                       SERIAL_TX_BIT_CLOCK_IN,
    input  wire logic                       SERIAL_RX_BIT_CLOCK_IN,
    input  wire logic                       SERIAL_RX_IN,
    input  wire hfcrc_pkg::hfcrc_tx_bit_t   TX_BIT_IN,
    input  wire hfcrc_pkg::hfcrc_rx_ctrl_t  RX_CTRL_IN,
    output logic                            SERIAL_TX_OUT,
    output logic                            TX_BIT_REQ_OUT,
    output logic                            TX_READY_OUT,
    output logic                            TX_CHECK_LAST_OUT,
    output hfcrc_pkg::hfcrc_rx_bit_t        RX_BIT_OUT,
    output hfcrc_pkg::hfcrc_rx_result_t     RX_RESULT_OUT
);
    import hfcrc_pkg::*;

    // one galois shift of the crc register; 16-bit modes use the low half
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic d,
                                             input logic wide);
        logic fb;
        fb = (wide ? c[31] : c[15]) ^ d;
        if (wide)
            crc_step = {c[30:0], 1'b0} ^ (fb ? HFCRC_POLY32 : HFCRC_ZEROS);
        else
            crc_step = {16'h0000, c[14:0], 1'b0} ^ (fb ? {16'h0000, HFCRC_POLY16} : HFCRC_ZEROS);
    endfunction

    // synchronisers for pins from outside the clock domain; stage 3 only for edges
    logic [2:0] tx_clk_sync;
    logic [2:0] rx_clk_sync;
    logic [1:0] rx_dat_sync;
    logic [1:0] dte_sync;

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            tx_clk_sync <= HFCRC_RST_SYNC;
            rx_clk_sync <= HFCRC_RST_SYNC;
            rx_dat_sync <= HFCRC_RST_SYNC[1:0];
            dte_sync    <= HFCRC_RST_SYNC[1:0];
        end
        else
        begin
            tx_clk_sync <= {tx_clk_sync[1:0], SERIAL_TX_BIT_CLOCK_IN};
            rx_clk_sync <= {rx_clk_sync[1:0], SERIAL_RX_BIT_CLOCK_IN};
            rx_dat_sync <= {rx_dat_sync[0], SERIAL_RX_IN};
            dte_sync    <= {dte_sync[0], DTE_TXD_IN};
        end
    end

    // edge finders; the modem samples on its rising edge, so we launch on falling
    wire tx_fall = tx_clk_sync[2] & ~tx_clk_sync[1];
    wire rx_rise = ~rx_clk_sync[2] & rx_clk_sync[1];

    // transmit side state
    hfcrc_txstate_t tx_state;
    hfcrc_txstate_t next_tx_state;
    hfcrc_mode_t    tx_mode;
    logic [31:0]    tx_crc;
    logic [31:0]    next_tx_crc;
    logic [5:0]     tx_cnt;
    logic [5:0]     next_tx_cnt;
    logic           pkt_line;
    logic           next_pkt_line;
    logic           tx_ready;
    logic           tx_last;
    logic           serial_tx;

    // mode seen by this slot: a frame start takes the fresh software choice
    wire            tx_fs      = TX_BIT_IN.frame_start;
    wire hfcrc_mode_t eff_mode = tx_fs ? CRC_MODE_IN : tx_mode;
    wire            eff_wide   = (eff_mode == HFCRC_MODE_CRC32);
    wire            eff_inv    = (eff_mode != HFCRC_MODE_CRC16);
    wire [5:0]      eff_len    = eff_wide ? HFCRC_LEN32 : HFCRC_LEN16;
    // ccitt and 32-bit preset ones, plain 16-bit presets zeros
    wire [31:0]     tx_preset  = (eff_mode == HFCRC_MODE_CRC16) ? HFCRC_ZEROS :
                                 (eff_wide ? HFCRC_ONES32 : HFCRC_ONES16);
    wire [31:0]     tx_base    = tx_fs ? tx_preset : tx_crc;
    wire            tx_msb     = eff_wide ? tx_base[31] : tx_base[15];
    wire            check_bit  = tx_msb ^ eff_inv;
    wire            is_check   = (TX_BIT_IN.kind == HFCRC_TXK_CHECK);

    assign TX_BIT_REQ_OUT = tx_fall;

    // next-state of the generator for the slot being requested
    always_comb
    begin
        next_tx_crc   = tx_base;
        next_tx_cnt   = tx_cnt;
        next_tx_state = tx_fs ? HFCRC_TX_BODY : tx_state;
        next_pkt_line = TX_BIT_IN.data;
        case (TX_BIT_IN.kind)
            HFCRC_TXK_DATA:
            begin
                next_tx_crc = crc_step(tx_base, TX_BIT_IN.data, eff_wide);
            end
            HFCRC_TXK_STUFF:
            begin
                next_tx_crc = tx_base;
            end
            HFCRC_TXK_CHECK:
            begin
                // shift the register out, high order first; zero fill behind it
                next_pkt_line = check_bit;
                next_tx_crc   = {tx_base[30:0], 1'b0};
                next_tx_cnt   = tx_cnt + 6'h01;
                next_tx_state = HFCRC_TX_CHECK;
                if (next_tx_cnt == eff_len)
                begin
                    next_tx_cnt   = 6'h00;
                    next_tx_state = HFCRC_TX_IDLE;
                end
            end
            HFCRC_TXK_FLAG:
            begin
                // closing flag, idle or abort: not covered
                next_tx_crc = tx_base;
                next_tx_cnt = 6'h00;
                if (!tx_fs)
                    next_tx_state = HFCRC_TX_IDLE;
            end
            default:
            begin
                next_tx_crc = tx_base;
            end
        endcase
    end

    // transmit registers, updated only on a bit slot
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            tx_state <= HFCRC_TX_IDLE;
            tx_mode  <= HFCRC_MODE_CCITT;
            tx_crc   <= HFCRC_ZEROS;
            tx_cnt   <= 6'h00;
            pkt_line <= HFCRC_RST_LINE;
        end
        else if (tx_fall)
        begin
            tx_state <= next_tx_state;
            tx_mode  <= eff_mode;
            tx_crc   <= next_tx_crc;
            tx_cnt   <= next_tx_cnt;
            pkt_line <= next_pkt_line;
        end
    end

    // ready pulses only for message bytes, held off through the check field
    wire next_tx_ready = tx_fall & (TX_BIT_IN.kind == HFCRC_TXK_DATA) &
                         TX_BIT_IN.byte_first & (tx_state != HFCRC_TX_CHECK);
    wire next_tx_last  = tx_fall & is_check & ((tx_cnt + 6'h01) == eff_len);

    // pin source select; clear channel uses the synchronised terminal input
    wire next_serial_tx = (TX_SRC_SEL_IN == HFCRC_SRC_CLEAR)  ? dte_sync[1] :
                          (TX_SRC_SEL_IN == HFCRC_SRC_STATIC) ? STATIC_LEVEL_IN :
                          pkt_line;

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            tx_ready  <= 1'b0;
            tx_last   <= 1'b0;
            serial_tx <= HFCRC_RST_LINE;
        end
        else
        begin
            tx_ready  <= next_tx_ready;
            tx_last   <= next_tx_last;
            serial_tx <= next_serial_tx;
        end
    end

    assign SERIAL_TX_OUT     = serial_tx;
    assign TX_READY_OUT      = tx_ready;
    assign TX_CHECK_LAST_OUT = tx_last;

    // receive sampling on the modem's rising edge
    hfcrc_rx_bit_t rx_bit;

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            rx_bit <= '0;
        else
            rx_bit <= '{valid: rx_rise, data: rx_rise ? rx_dat_sync[1] : rx_bit.data};
    end

    assign RX_BIT_OUT = rx_bit;

    // receive checker; the packetizer shifts only de-stuffed non-flag bits
    hfcrc_mode_t      rx_mode;
    logic [31:0]      rx_crc;
    hfcrc_rx_result_t rx_result;

    wire        rx_wide   = (rx_mode == HFCRC_MODE_CRC32);
    // every mode starts the receive register at all ones
    wire [31:0] rx_preset = (CRC_MODE_IN == HFCRC_MODE_CRC32) ? HFCRC_ONES32 : HFCRC_ONES16;
    wire        rx_res_ok = rx_wide ? (rx_crc == HFCRC_RESIDUE32) :
                                      (rx_crc[15:0] == HFCRC_RESIDUE16);

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            rx_mode   <= HFCRC_MODE_CCITT;
            rx_crc    <= HFCRC_ONES32;
            rx_result <= '0;
        end
        else
        begin
            rx_result <= '{done: RX_CTRL_IN.frame_close,
                           crc_bad: RX_CTRL_IN.frame_close & ~rx_res_ok};
            if (RX_CTRL_IN.frame_start)
            begin
                rx_mode <= CRC_MODE_IN;
                rx_crc  <= rx_preset;
            end
            else if (RX_CTRL_IN.shift)
                rx_crc <= crc_step(rx_crc, RX_CTRL_IN.data, rx_wide);
        end
    end

    assign RX_RESULT_OUT = rx_result;

    // checks on the transmit generator
    property p_stuff_hold;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        tx_fall && !tx_fs && TX_BIT_IN.kind == HFCRC_TXK_STUFF |=> $stable(tx_crc);
    endproperty
    a_stuff_hold: assert property (p_stuff_hold) else $error("stuffed bit moved crc");

    property p_poly16_feed;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        tx_fall && !tx_fs && TX_BIT_IN.kind == HFCRC_TXK_DATA && tx_mode != HFCRC_MODE_CRC32
        |=> tx_crc[0] == $past(tx_crc[15] ^ TX_BIT_IN.data) && tx_crc[31:16] == 16'h0000;
    endproperty
    a_poly16_feed: assert property (p_poly16_feed) else $error("16-bit feedback wrong");

    property p_ccitt_preset;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        tx_fall && tx_fs && CRC_MODE_IN == HFCRC_MODE_CCITT && TX_BIT_IN.kind == HFCRC_TXK_DATA
        |=> tx_crc == ($past(TX_BIT_IN.data) ? 32'h0000FFFE : 32'h0000EFDF);
    endproperty
    a_ccitt_preset: assert property (p_ccitt_preset) else $error("ccitt preset wrong");

    property p_crc16_preset;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        tx_fall && tx_fs && CRC_MODE_IN == HFCRC_MODE_CRC16 && TX_BIT_IN.kind == HFCRC_TXK_DATA
        |=> tx_crc == ($past(TX_BIT_IN.data) ? 32'h00001021 : 32'h00000000);
    endproperty
    a_crc16_preset: assert property (p_crc16_preset) else $error("crc16 preset wrong");

    property p_check_inverted;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        tx_fall && is_check && !tx_fs && tx_mode != HFCRC_MODE_CRC16
        |=> pkt_line == !$past(tx_mode == HFCRC_MODE_CRC32 ? tx_crc[31] : tx_crc[15]);
    endproperty
    a_check_inverted: assert property (p_check_inverted) else $error("check not inverted");

    property p_check_plain;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        tx_fall && is_check && !tx_fs && tx_mode == HFCRC_MODE_CRC16
        |=> pkt_line == $past(tx_crc[15]);
    endproperty
    a_check_plain: assert property (p_check_plain) else $error("plain check bit wrong");

    property p_ready_quiet;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        tx_fall && (is_check || tx_state == HFCRC_TX_CHECK) |=> !TX_READY_OUT;
    endproperty
    a_ready_quiet: assert property (p_ready_quiet) else $error("ready in check field");

    property p_mode_stable;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        !(tx_fall && tx_fs) |=> $stable(tx_mode);
    endproperty
    a_mode_stable: assert property (p_mode_stable) else $error("mode changed mid frame");

    property p_static_pin;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        TX_SRC_SEL_IN == HFCRC_SRC_STATIC |=> SERIAL_TX_OUT == $past(STATIC_LEVEL_IN);
    endproperty
    a_static_pin: assert property (p_static_pin) else $error("static level not on pin");

    property p_tx_on_edge;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        $changed(pkt_line) |-> $past(tx_clk_sync[2] & ~tx_clk_sync[1]);
    endproperty
    a_tx_on_edge: assert property (p_tx_on_edge) else $error("tx bit off clock edge");

    // checks on the receive checker
    property p_rx_preset;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        RX_CTRL_IN.frame_start |=> rx_crc[15:0] == 16'hFFFF;
    endproperty
    a_rx_preset: assert property (p_rx_preset) else $error("receive preset not ones");

    property p_rx_verdict;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        RX_CTRL_IN.frame_close && rx_mode != HFCRC_MODE_CRC32 && rx_crc[15:0] != HFCRC_RESIDUE16
        |=> RX_RESULT_OUT.done && RX_RESULT_OUT.crc_bad;
    endproperty
    a_rx_verdict: assert property (p_rx_verdict) else $error("bad residue not flagged");

    property p_rx_sample;
        @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
        RX_BIT_OUT.valid |-> $past(rx_clk_sync[1] & ~rx_clk_sync[2]) && !$past(RX_BIT_OUT.valid);
    endproperty
    a_rx_sample: assert property (p_rx_sample) else $error("rx bit off clock edge");

endmodule

// File: dv/hfcrc_modem_model.sv
// modem model: serial bit clocks and receive data line
module hfcrc_modem_model
(
    input  wire logic        tx_run_in,
    input  wire logic        rx_start_in,
    input  wire logic [63:0] rx_bits_in,
    input  wire logic [6:0]  rx_len_in,
    output logic             tx_clk_out,
    output logic             rx_clk_out,
    output logic             rx_data_out,
    output logic             rx_busy_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // tx bit clock runs only while a frame goes out, idle high
    initial
    begin
        tx_clk_out = 1'b1;
        forever
        begin
            wait (tx_run_in);
            #400 tx_clk_out = 1'b0;
            #400 tx_clk_out = 1'b1;
        end
    end

    // rx bit changes on the fall, so it is steady at the sampling rise
    initial
    begin
        rx_clk_out = 1'b1;
        rx_data_out = 1'b1;
        rx_busy_out = 1'b0;
        forever
        begin
            @(posedge rx_start_in);
            rx_busy_out = 1'b1;
            for (int i = 0; i < rx_len_in; i++)
            begin
                #400 rx_clk_out = 1'b0;
                rx_data_out = rx_bits_in[i];
                #400 rx_clk_out = 1'b1;
            end
            // hold time over: show the inverse, never a stale bit
            #400 rx_data_out = ~rx_data_out;
            rx_busy_out = 1'b0;
        end
    end
endmodule

// File: dv/hfcrc_unit_tb.sv
// self-checking bench of the hdlc frame check unit
module hfcrc_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import hfcrc_pkg::*;

    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    hfcrc_mode_t      mode = HFCRC_MODE_CCITT;
    hfcrc_txsrc_t     src = HFCRC_SRC_PACKETIZER;
    logic             static_lvl = 1'b0;
    logic             dte_txd = 1'b1;
    hfcrc_tx_bit_t    tx_bit = '0;
    hfcrc_rx_ctrl_t   rx_ctrl = '0;
    logic             tx_run = 1'b0;
    logic             rx_start = 1'b0;
    logic [63:0]      rx_bits = '0;
    logic [6:0]       rx_len = '0;
    logic             tx_clk, rx_clk, rx_data, rx_busy;
    logic             ser_tx, bit_req, tx_ready, chk_last;
    hfcrc_rx_bit_t    rx_bit;
    hfcrc_rx_result_t rx_res;
    int               failures = 0;
    int               checks = 0;

    always #50 clk = ~clk;

    hfcrc_modem_model modem_u (.tx_run_in(tx_run), .rx_start_in(rx_start),
        .rx_bits_in(rx_bits), .rx_len_in(rx_len), .tx_clk_out(tx_clk),
        .rx_clk_out(rx_clk), .rx_data_out(rx_data), .rx_busy_out(rx_busy));

    hfcrc_unit dut_u (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .CRC_MODE_IN(mode),
        .TX_SRC_SEL_IN(src), .STATIC_LEVEL_IN(static_lvl), .DTE_TXD_IN(dte_txd),
        .SERIAL_TX_BIT_CLOCK_IN(tx_clk), .SERIAL_RX_BIT_CLOCK_IN(rx_clk),
        .SERIAL_RX_IN(rx_data), .TX_BIT_IN(tx_bit), .RX_CTRL_IN(rx_ctrl),
        .SERIAL_TX_OUT(ser_tx), .TX_BIT_REQ_OUT(bit_req), .TX_READY_OUT(tx_ready),
        .TX_CHECK_LAST_OUT(chk_last), .RX_BIT_OUT(rx_bit), .RX_RESULT_OUT(rx_res));

    // shared compare and verdict
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // reference shift: msb feedback, left shift, polynomial from the terms
    function automatic logic [31:0] crc_step(logic [31:0] r, logic b, int w);
        logic fb;
        fb = r[w-1] ^ b;
        r = (r << 1) & ((w == 32) ? 32'hFFFFFFFF : 32'h0000FFFF);
        if (fb)
            r = r ^ ((w == 32) ? 32'h04C11DB7 : 32'h00001021);
        return r;
    endfunction

    // one tx slot: hold the slot until taken, then read pulses and pin
    task automatic tx_slot(input hfcrc_tx_bit_t s, output logic sent, output logic rdy,
                           output logic last);
        int n;
        n = 0;
        tx_bit = s;
        while (bit_req !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 40)
            failures++;
        @(posedge clk);
        #1;
        rdy = tx_ready;
        last = chk_last;
        @(posedge clk);
        #1;
        sent = ser_tx;
    endtask

    task automatic tx_frame(input hfcrc_mode_t m, input int w, input logic [31:0] pre,
                            input logic inv, input logic [15:0] d);
        hfcrc_tx_bit_t s;
        logic [31:0]   r;
        logic          sent, rdy, last;
        r = pre;
        mode = m;
        tx_run = 1'b1;
        tx_slot('{HFCRC_TXK_FLAG, 1'b0, 1'b0, 1'b0}, sent, rdy, last);
        for (int i = 0; i < 16; i++)
        begin
            s = '{HFCRC_TXK_DATA, d[i], i == 0, i % 8 == 0};
            tx_slot(s, sent, rdy, last);
            r = crc_step(r, d[i], w);
            check("tx_data", sent, d[i]);
            check("tx_ready", rdy, i % 8 == 0);
            if (i == 4)
            begin
                tx_slot('{HFCRC_TXK_STUFF, 1'b0, 1'b0, 1'b0}, sent, rdy, last);
                check("stuff_ready", rdy, 1'b0);
            end
        end
        // check slots carry a wrong data bit and byte_first on purpose
        for (int i = w - 1; i >= 0; i--)
        begin
            s = '{HFCRC_TXK_CHECK, ~(r[i] ^ inv), 1'b0, i % 8 == 7};
            tx_slot(s, sent, rdy, last);
            check("check_bit", sent, r[i] ^ inv);
            check("check_ready", rdy, 1'b0);
            check("check_last", last, i == 0);
        end
        tx_slot('{HFCRC_TXK_FLAG, 1'b0, 1'b0, 1'b0}, sent, rdy, last);
        tx_run = 1'b0;
    endtask

    // rx frame: bit 5 is a stuffed zero on the wire that is never shifted
    task automatic rx_frame(input hfcrc_mode_t m, input int w, input logic [15:0] d,
                            input int flip);
        logic [31:0] r, t;
        logic        bad;
        int          k, n;
        r = 32'hFFFFFFFF >> (32 - w);
        t = r;
        k = 0;
        for (int i = 0; i < 16; i++)
        begin
            r = crc_step(r, d[i], w);
            rx_bits[k++] = d[i];
            if (i == 4)
                rx_bits[k++] = 1'b0;
        end
        for (int i = w - 1; i >= 0; i--)
            rx_bits[k++] = ~r[i];
        if (flip >= 0)
            rx_bits[flip] = ~rx_bits[flip];
        rx_len = 7'(k);
        for (int j = 0; j < k; j++)
            if (j != 5)
                t = crc_step(t, rx_bits[j], w);
        bad = (w == 32) ? (t !== 32'hC704DD7B) : (t[15:0] !== 16'h1D0F);
        wait (rx_busy == 1'b0);
        // let an edge pass so the previous close strobe is not rewritten in its own step
        @(posedge clk);
        #1;
        mode = m;
        rx_ctrl.frame_start = 1'b1;
        @(posedge clk);
        #1;
        rx_ctrl = '0;
        rx_start = 1'b1;
        for (int j = 0; j < k; j++)
        begin
            n = 0;
            while (rx_bit.valid !== 1'b1 && n < 40)
            begin
                @(negedge clk);
                n++;
            end
            if (n >= 40)
                failures++;
            check("rx_bit", rx_bit.data, rx_bits[j]);
            @(posedge clk);
            #1;
            rx_ctrl.shift = (j != 5);
            rx_ctrl.data = rx_bits[j];
            @(posedge clk);
            #1;
            rx_ctrl = '0;
        end
        rx_start = 1'b0;
        @(posedge clk);
        #1;
        rx_ctrl.frame_close = 1'b1;
        @(posedge clk);
        #1;
        rx_ctrl = '0;
        check("rx_done", rx_res.done, 1'b1);
        check("crc_bad", rx_res.crc_bad, bad);
    endtask

    // pin source: static level after one register, clear channel after three
    task automatic test_tx_source();
        src = HFCRC_SRC_STATIC;
        for (int v = 0; v < 2; v++)
        begin
            static_lvl = v[0];
            @(posedge clk);
            #1;
            check("static_pin", ser_tx, v[0]);
        end
        src = HFCRC_SRC_CLEAR;
        for (int v = 0; v < 2; v++)
        begin
            dte_txd = v[0];
            repeat (3) @(posedge clk);
            #1;
            check("clear_pin", ser_tx, v[0]);
        end
        src = HFCRC_SRC_PACKETIZER;
    endtask

    task automatic test_tx_ccitt();
        tx_frame(HFCRC_MODE_CCITT, 16, 32'h0000FFFF, 1'b1, 16'hA53C);
    endtask

    task automatic test_tx_crc16();
        tx_frame(HFCRC_MODE_CRC16, 16, 32'h00000000, 1'b0, 16'h5AC3);
    endtask

    task automatic test_tx_crc32();
        tx_frame(HFCRC_MODE_CRC32, 32, 32'hFFFFFFFF, 1'b1, 16'h0FF1);
    endtask

    task automatic test_rx_modes();
        rx_frame(HFCRC_MODE_CCITT, 16, 16'hC0DE, -1);
        rx_frame(HFCRC_MODE_CRC16, 16, 16'h1234, -1);
        rx_frame(HFCRC_MODE_CRC32, 32, 16'hBEEF, -1);
    endtask

    task automatic test_rx_bad();
        rx_frame(HFCRC_MODE_CCITT, 16, 16'hC0DE, 20);
        rx_frame(HFCRC_MODE_CRC32, 32, 16'hBEEF, 3);
    endtask

    // main sequence
    initial
    begin
        repeat (11) @(posedge clk);
        #1;
        check("reset_line", ser_tx, 1'b1);
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        test_tx_source();
        test_tx_ccitt();
        test_tx_crc16();
        test_tx_crc32();
        test_rx_modes();
        test_rx_bad();
        end_of_test();
    end

    // watchdog well beyond the expected quarter millisecond of traffic
    initial
    begin
        #2000000;
        failures++;
        end_of_test();
    end
endmodule
